// ### inc/ddcw_pkg.sv
package ddcw_pkg;
  // ******************************************************************
  // Word indices on the bus
  // ******************************************************************
  localparam logic [1:0] WORD0 = 2'h0;
  localparam logic [1:0] WORD1 = 2'h1;
  localparam logic [1:0] WORD2 = 2'h2;
  localparam logic [1:0] WORD3 = 2'h3;
  // Command word 0 fields
  localparam int UNIT_ID_MSB = 7;
  localparam int UNIT_ID_LSB = 4;
  // Command word 2 fields
  localparam int OFS_REV_BIT = 7;
  localparam int OFS_FWD_BIT = 6;
  localparam int STB_LATE_BIT = 5;
  localparam int STB_EARLY_BIT = 4;
  // Command word 3 fields
  localparam int DIAG_BIT = 7;
  localparam int REZERO_BIT = 5;
  localparam int FCLR_BIT = 4;
  // Status word 0 bit positions
  localparam int SW0_NOT_READY = 7;
  localparam int SW0_SERVO_ERR = 6;
  localparam int SW0_RW_FAULT = 5;
  localparam int SW0_SPEED_ERR = 4;
  localparam int SW0_PWR_LOSS = 3;
  localparam int SW0_WPROT = 2;
  localparam int SW0_SEEKING = 1;
  localparam int SW0_NOT_ON_CYL = 0;
  // Status word 1 bit positions
  localparam int SW1_INVALID = 4;
  localparam int SW1_TIMEOUT = 3;
  localparam int SW1_ILL_ADDR = 1;
  localparam int SW1_INT_ERR = 0;
  // Sector size codes, one-hot from 128 bytes
  localparam logic [7:0] SSIZE_128 = 8'h01;
  localparam logic [7:0] SSIZE_4096 = 8'h20;
  // Head count codes
  localparam logic [7:0] HEADS_3 = 8'h03;
  localparam logic [7:0] HEADS_5 = 8'h05;
  // Rezero longest time, milliseconds and cycles at 50 MHz
  localparam int CLK_HZ = 50000000;
  localparam int REZERO_MS = 800;
  localparam int REZERO_CYC = (CLK_HZ / 1000) * REZERO_MS;
endpackage

// ### inc/ddcw_cmd_if.sv
`timescale 1ns/1ps
// Accepted command word from handshake unit to the decoder
interface ddcw_cmd_if;
  logic take; // One-cycle pulse: word accepted
  logic [1:0] idx; // Word index
  logic [7:0] data; // Command byte
  modport src (output take, output idx, output data);
  modport dst (input take, input idx, input data);
endinterface // ddcw_cmd_if

// ### logic/ddcw_handshake.sv
`timescale 1ns/1ps
// ******************************************************************
// Attention / cycle acknowledge handshake with pin synchronisers
// ******************************************************************
module ddcw_handshake (
  input wire logic clk,
  input wire logic nrst,
  input wire logic attn_pin,
  input wire logic dir_pin,
  input wire logic word_index_bit0,
  input wire logic word_index_bit1,
  input wire logic [7:0] bus_in,
  input wire logic selected,
  output logic cycle_ack_line,
  output logic status_phase,
  output logic [1:0] cur_idx,
  ddcw_cmd_if.src cmd
);
  // Three-stage synchronisers for all pins, one vector
  logic [11:0] s1_r, s2_r, s3_r;
  logic [11:0] stable_r; // Value once stages two and three agree
  logic ack_r; // Acknowledge held until attention drops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 12'h000;
      s2_r <= 12'h000;
      s3_r <= 12'h000;
    end else begin
      s1_r <= {attn_pin, dir_pin, word_index_bit1, word_index_bit0, bus_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Accept a change once two stages agree, filtering glitches
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stable_r <= 12'h000;
    end else begin
      for (int i = 0; i < 12; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          stable_r[i] <= s3_r[i];
        end
      end
    end
  end
  wire attn = stable_r[11];
  wire dir = stable_r[10];
  // Take word on attention rise; drop ack after attention drops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else if (!ack_r && attn && (selected || (dir && stable_r[9:8] == 2'h0))) begin
      ack_r <= 1'b1;
    end else if (ack_r && !attn) begin
      ack_r <= 1'b0;
    end
  end
  assign cycle_ack_line = ack_r;
  assign cmd.take = !ack_r && attn && dir && (selected || stable_r[9:8] == 2'h0);
  assign cmd.idx = stable_r[9:8];
  assign cmd.data = stable_r[7:0];
  assign status_phase = !dir;
  assign cur_idx = stable_r[9:8];
  // ******************************************************************
  // Checks
  // ******************************************************************
  a_ack_release: assert property (@(posedge clk) disable iff (!nrst)
    (ack_r && !attn) |=> !ack_r) else $error("ack held after attention dropped");
  a_take_pulse: assert property (@(posedge clk) disable iff (!nrst)
    cmd.take |=> ack_r && !cmd.take) else $error("take not acknowledged");
endmodule // ddcw_handshake

// ### logic/ddcw_top.sv
`timescale 1ns/1ps
module ddcw_top #(
  parameter int REZERO_CYCLES = ddcw_pkg::REZERO_CYC,
  parameter logic [2:0] SERVO_HEAD = 3'h3,
  parameter logic [7:0] SECTORS_PER_TRACK = 8'h20,
  parameter logic [7:0] SECTOR_SIZE_CODE = ddcw_pkg::SSIZE_128,
  parameter logic [7:0] DATA_HEADS_CODE = ddcw_pkg::HEADS_3,
  parameter logic [7:0] PERIPH_TYPE = 8'h5A // Arbitrary value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic attn_pin,
  input wire logic dir_pin,
  input wire logic word_index_bit0,
  input wire logic word_index_bit1,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic bus_oe_n,
  output logic cycle_ack_line,
  input wire logic [3:0] unit_straps,
  input wire logic [2:0] jumper_wprot,
  input wire logic read_enable,
  input wire logic write_enable,
  input wire logic speed_err_in,
  input wire logic power_loss_in,
  input wire logic not_ready_in,
  output logic drive_selected,
  output logic fault,
  output logic [9:0] cylinder_target_reg,
  output logic [2:0] head_select_field,
  output logic offset_fwd,
  output logic offset_rev,
  output logic strobe_early,
  output logic strobe_late,
  output logic seek_start,
  output logic seek_end,
  output logic diag_mode
);
  // ******************************************************************
  // Handshake and decoded command strobes
  // ******************************************************************
  ddcw_cmd_if cmd ();
  logic status_phase;
  logic [1:0] cur_idx;
  logic selected_r;
  ddcw_handshake u_hs (
    .clk(clk),
    .nrst(nrst),
    .attn_pin(attn_pin),
    .dir_pin(dir_pin),
    .word_index_bit0(word_index_bit0),
    .word_index_bit1(word_index_bit1),
    .bus_in(bus_in),
    .selected(selected_r),
    .cycle_ack_line(cycle_ack_line),
    .status_phase(status_phase),
    .cur_idx(cur_idx),
    .cmd(cmd)
  );
  // Decode a word strobe for a given index
  function automatic logic is_word(input logic take, input logic [1:0] idx,
                                   input logic [1:0] want);
    return take && (idx == want);
  endfunction
  wire w0 = is_word(cmd.take, cmd.idx, ddcw_pkg::WORD0);
  // Words 1 to 3 only count on the selected drive
  wire w1 = is_word(cmd.take, cmd.idx, ddcw_pkg::WORD1) && selected_r;
  wire w2 = is_word(cmd.take, cmd.idx, ddcw_pkg::WORD2) && selected_r;
  wire w3 = is_word(cmd.take, cmd.idx, ddcw_pkg::WORD3) && selected_r;
  wire [3:0] unit_id_field = cmd.data[ddcw_pkg::UNIT_ID_MSB:ddcw_pkg::UNIT_ID_LSB];
  // ******************************************************************
  // Selection
  // ******************************************************************
  // Any word 0 reselects; a mismatch deselects this drive
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      selected_r <= 1'b0;
    end else if (w0) begin
      selected_r <= (unit_id_field == unit_straps);
    end
  end
  assign drive_selected = selected_r;
  // ******************************************************************
  // Cylinder target and seek start
  // ******************************************************************
  logic hi_loaded_r; // Word 0 handshake done, awaiting word 1
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cylinder_target_reg <= 10'h000;
    end else if (w0 && unit_id_field == unit_straps) begin
      cylinder_target_reg[9:8] <= cmd.data[1:0];
    end else if (w1) begin
      cylinder_target_reg[7:0] <= cmd.data;
    end
  end
  // Seek fires once both halves are in; ack completes in handshake unit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hi_loaded_r <= 1'b0;
      seek_start <= 1'b0;
    end else begin
      seek_start <= w1 && hi_loaded_r;
      if (w0) begin
        hi_loaded_r <= (unit_id_field == unit_straps);
      end else if (w1) begin
        hi_loaded_r <= 1'b0;
      end
    end
  end
  // ******************************************************************
  // Command word 2: head, offset, strobe
  // ******************************************************************
  // Head, offset and strobe bits latch only on an accepted word 2
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      head_select_field <= 3'h0;
      offset_fwd <= 1'b0;
      offset_rev <= 1'b0;
      strobe_early <= 1'b0;
      strobe_late <= 1'b0;
    end else if (w2) begin
      head_select_field <= cmd.data[2:0];
      offset_fwd <= cmd.data[ddcw_pkg::OFS_FWD_BIT];
      offset_rev <= cmd.data[ddcw_pkg::OFS_REV_BIT];
      strobe_early <= cmd.data[ddcw_pkg::STB_EARLY_BIT];
      strobe_late <= cmd.data[ddcw_pkg::STB_LATE_BIT];
    end
  end
  // Heads 0..4 only; servo head and codes above 4 are illegal
  wire head_illegal = (head_select_field > 3'h4) || (head_select_field == SERVO_HEAD);
  wire w2_servo = w2 && ((cmd.data[2:0] == SERVO_HEAD) || (cmd.data[2:0] > 3'h4));
  // ******************************************************************
  // Command word 3: diagnostic, write protect
  // ******************************************************************
  logic [2:0] cmd_wprot_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      diag_mode <= 1'b0;
      cmd_wprot_r <= 3'h0;
    end else if (w3) begin
      diag_mode <= cmd.data[ddcw_pkg::DIAG_BIT];
      cmd_wprot_r <= cmd.data[2:0];
    end
  end
  // Jumpers always protect; command bits can only add
  wire [2:0] wprot = cmd_wprot_r | jumper_wprot;
  wire head_prot = (head_select_field < 3'h3) ? wprot[head_select_field[1:0]] : 1'b0;
  wire rezero_cmd = w3 && cmd.data[ddcw_pkg::REZERO_BIT];
  wire fclr_cmd = w3 && cmd.data[ddcw_pkg::FCLR_BIT];
  // ******************************************************************
  // Rezero sequencing
  // ******************************************************************
  typedef enum logic {DDCW_IDLE, DDCW_REZERO} ddcw_rz_t;
  ddcw_rz_t rz_r;
  logic [$clog2(REZERO_CYCLES + 1)-1:0] rz_cnt_r;
  logic servo_err_r;
  logic seeking_r;
  logic not_on_cyl_r;
  // Modelled carriage travel takes the full worst-case time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rz_r <= DDCW_IDLE;
      rz_cnt_r <= '0;
      seeking_r <= 1'b0;
      not_on_cyl_r <= 1'b0;
      seek_end <= 1'b1;
    end else begin
      case (rz_r)
        DDCW_IDLE: begin
          if (rezero_cmd) begin
            rz_r <= DDCW_REZERO;
            rz_cnt_r <= '0;
            seeking_r <= 1'b1;
            not_on_cyl_r <= 1'b1;
            seek_end <= 1'b0;
          end
        end
        DDCW_REZERO: begin
          if (rz_cnt_r >= ($bits(rz_cnt_r))'(REZERO_CYCLES - 1)) begin
            rz_r <= DDCW_IDLE;
            seeking_r <= 1'b0;
            not_on_cyl_r <= 1'b0;
            seek_end <= 1'b1;
          end else begin
            rz_cnt_r <= rz_cnt_r + 1'b1;
          end
        end
        default: rz_r <= DDCW_IDLE;
      endcase
    end
  end
  // Servo error only leaves through rezero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      servo_err_r <= 1'b0;
    end else if (rezero_cmd) begin
      servo_err_r <= 1'b0;
    end
  end
  // ******************************************************************
  // Fault and error flags
  // ******************************************************************
  logic rw_fault_r, speed_err_r, pwr_loss_r, invalid_r, timeout_r;
  logic ill_addr_r, int_err_r, wprot_flag_r;
  // Write gate while offset, strobe, or protected head is bad
  wire write_bad = write_enable && selected_r &&
                   (offset_fwd || offset_rev || strobe_early || strobe_late || head_prot);
  wire both_gates = read_enable && write_enable && selected_r;
  // Sets win over fault clear so a coincident event is kept
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rw_fault_r <= 1'b0;
      speed_err_r <= 1'b0;
      pwr_loss_r <= 1'b0;
      invalid_r <= 1'b0;
      timeout_r <= 1'b0;
      ill_addr_r <= 1'b0;
      int_err_r <= 1'b0;
    end else begin
      if (fclr_cmd) begin
        rw_fault_r <= 1'b0;
        speed_err_r <= 1'b0;
        pwr_loss_r <= 1'b0;
        invalid_r <= 1'b0;
        timeout_r <= 1'b0;
        ill_addr_r <= 1'b0;
        int_err_r <= 1'b0;
      end
      if (write_bad) begin
        rw_fault_r <= 1'b1;
      end
      if (speed_err_in) begin
        speed_err_r <= 1'b1;
      end
      if (power_loss_in) begin
        pwr_loss_r <= 1'b1;
      end
      if (w2_servo || both_gates) begin
        invalid_r <= 1'b1;
      end
      if (w2_servo) begin
        ill_addr_r <= 1'b1;
      end
    end
  end
  // Write protected bit: servo select or protected head
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wprot_flag_r <= 1'b0;
    end else if (w2_servo) begin
      wprot_flag_r <= 1'b1;
    end else if (w2) begin
      wprot_flag_r <= 1'b0;
    end
  end
  // Fault line from latched flags except servo error, timeout and write protect, plus a live bad write or servo select
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault <= 1'b0;
    end else begin
      fault <= rw_fault_r || speed_err_r || pwr_loss_r || invalid_r ||
               ill_addr_r || int_err_r || write_bad || w2_servo;
    end
  end
  // ******************************************************************
  // Status words
  // ******************************************************************
  logic [7:0] sw0, sw1, stat;
  always_comb begin
    sw0 = 8'h00;
    sw0[ddcw_pkg::SW0_NOT_READY] = not_ready_in || speed_err_r;
    sw0[ddcw_pkg::SW0_SERVO_ERR] = servo_err_r;
    sw0[ddcw_pkg::SW0_RW_FAULT] = rw_fault_r;
    sw0[ddcw_pkg::SW0_SPEED_ERR] = speed_err_r;
    sw0[ddcw_pkg::SW0_PWR_LOSS] = pwr_loss_r;
    sw0[ddcw_pkg::SW0_WPROT] = wprot_flag_r || (head_prot && !head_illegal);
    sw0[ddcw_pkg::SW0_SEEKING] = seeking_r;
    sw0[ddcw_pkg::SW0_NOT_ON_CYL] = not_on_cyl_r || offset_fwd || offset_rev;
    sw1 = 8'h00;
    sw1[ddcw_pkg::SW1_INVALID] = invalid_r;
    sw1[ddcw_pkg::SW1_TIMEOUT] = timeout_r;
    sw1[ddcw_pkg::SW1_ILL_ADDR] = ill_addr_r;
    sw1[ddcw_pkg::SW1_INT_ERR] = int_err_r;
  end
  // Diagnostic words replace the standard set
  always_comb begin
    if (diag_mode) begin
      case (cur_idx)
        ddcw_pkg::WORD0: stat = SECTORS_PER_TRACK;
        ddcw_pkg::WORD1: stat = SECTOR_SIZE_CODE;
        ddcw_pkg::WORD2: stat = DATA_HEADS_CODE;
        default: stat = PERIPH_TYPE;
      endcase
    end else begin
      case (cur_idx)
        ddcw_pkg::WORD0: stat = sw0;
        ddcw_pkg::WORD1: stat = sw1;
        ddcw_pkg::WORD2: stat = {6'h00, cylinder_target_reg[9:8]};
        default: stat = cylinder_target_reg[7:0];
      endcase
    end
  end
  // Drive status only when selected and direction inactive
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_out <= 8'h00;
      bus_oe_n <= 1'b1;
    end else begin
      bus_out <= stat;
      bus_oe_n <= !(selected_r && status_phase);
    end
  end
  // ******************************************************************
  // Checks
  // ******************************************************************
  a_rezero_start: assert property (@(posedge clk) disable iff (!nrst)
    (rezero_cmd && rz_r == DDCW_IDLE) |=> !seek_end && seeking_r && !servo_err_r)
    else $error("rezero did not start");
  a_fclr_clears: assert property (@(posedge clk) disable iff (!nrst)
    (fclr_cmd && !write_bad && !both_gates && !speed_err_in && !power_loss_in && !w2_servo)
    |=> !rw_fault_r && !speed_err_r && !invalid_r) else $error("fault clear failed");
  a_write_fault: assert property (@(posedge clk) disable iff (!nrst)
    write_bad |=> fault && rw_fault_r) else $error("bad write not faulted");
  a_servo_head: assert property (@(posedge clk) disable iff (!nrst)
    w2_servo |=> invalid_r && ill_addr_r && wprot_flag_r) else $error("servo select missed");
  a_select_match: assert property (@(posedge clk) disable iff (!nrst)
    w0 |=> selected_r == $past(unit_id_field == unit_straps)) else $error("selection wrong");
  a_cyl_high: assert property (@(posedge clk) disable iff (!nrst)
    (w0 && unit_id_field == unit_straps) |=> cylinder_target_reg[9:8] == $past(cmd.data[1:0]))
    else $error("cylinder high bits wrong");
  a_seek_pair: assert property (@(posedge clk) disable iff (!nrst)
    seek_start |-> $past(w1)) else $error("seek without word 1");
  a_diag_enter: assert property (@(posedge clk) disable iff (!nrst)
    (w3 && cmd.data[ddcw_pkg::DIAG_BIT]) |=> diag_mode) else $error("diag not entered");
  a_quiet_unsel: assert property (@(posedge clk) disable iff (!nrst)
    !$past(selected_r) |-> bus_oe_n) else $error("unselected drive drove bus");
endmodule // ddcw_top

// ### dv/ddcw_ctrl_model.sv
`timescale 1ns/1ps
// ****
// Controller side of the control bus
// ****
module ddcw_ctrl_model (
  input wire logic clk,
  output logic attn_pin,
  output logic dir_pin,
  output logic word_index_bit0,
  output logic word_index_bit1,
  output logic [7:0] bus_in,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe_n,
  input wire logic cycle_ack_line
);
  // Idle lines at time zero
  initial begin
    attn_pin = 1'b0;
    dir_pin = 1'b0;
    {word_index_bit1, word_index_bit0} = 2'h0;
    bus_in = 8'hA5;
  end
  // One handshake; ok stays low if never acked
  task automatic xfer(input logic d, input logic [1:0] i, input logic [7:0] v,
                      output logic ok, output logic [7:0] rd);
    int n;
    ok = 1'b0;
    rd = 8'h00;
    @(posedge clk);
    dir_pin <= d;
    {word_index_bit1, word_index_bit0} <= i;
    // A released bus must not keep its old value
    bus_in <= d ? v : ~bus_in;
    // Setup; head bits move only with gates idle
    repeat (6) @(posedge clk);
    attn_pin <= 1'b1;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      if (cycle_ack_line === 1'b1) begin
        ok = 1'b1;
        rd = (bus_oe_n === 1'b0) ? bus_out : 8'hEE;
      end
    end
    attn_pin <= 1'b0;
    for (n = 0; n < 20 && cycle_ack_line !== 1'b0; n++) @(posedge clk);
    @(posedge clk);
  endtask
endmodule // ddcw_ctrl_model

// ### dv/disk_drive_control_word_decoder_test.sv
`timescale 1ns/1ps
module disk_drive_control_word_decoder_test;
  // ****
  // Signals
  // ****
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic attn_pin, dir_pin, word_index_bit0, word_index_bit1;
  logic [7:0] bus_in, bus_out;
  logic bus_oe_n, cycle_ack_line, drive_selected, fault;
  logic [2:0] jumper_wprot = 3'h0; // Strapped protection
  logic write_enable = 1'b0;
  logic [3:0] straps = 4'h9; // Strapped unit id
  logic read_enable = 1'b0;
  logic speed_err_in = 1'b0; // Sensor levels, sticky in the drive
  logic power_loss_in = 1'b0;
  logic not_ready_in = 1'b0;
  logic [9:0] cylinder_target_reg;
  logic [2:0] head_select_field;
  logic offset_fwd, offset_rev, strobe_early, strobe_late;
  logic seek_start, seek_end, diag_mode;
  int n_fail = 0;
  int comparisons = 0;
  int n_seek = 0; // Seek start pulses seen
  // 50 MHz clock
  always #10 clk = ~clk;
  // Short rezero keeps the run brief
  ddcw_top #(.REZERO_CYCLES(200), .SECTORS_PER_TRACK(8'h11),
    .SECTOR_SIZE_CODE(8'h04), .DATA_HEADS_CODE(8'h05),
    .PERIPH_TYPE(8'h3C)) dut (.clk(clk), .nrst(nrst), .attn_pin(attn_pin),
    .dir_pin(dir_pin), .word_index_bit0(word_index_bit0),
    .word_index_bit1(word_index_bit1), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe_n(bus_oe_n), .cycle_ack_line(cycle_ack_line),
    .unit_straps(straps), .jumper_wprot(jumper_wprot), .read_enable(read_enable),
    .write_enable(write_enable), .speed_err_in(speed_err_in),
    .power_loss_in(power_loss_in), .not_ready_in(not_ready_in),
    .drive_selected(drive_selected), .fault(fault),
    .cylinder_target_reg(cylinder_target_reg),
    .head_select_field(head_select_field), .offset_fwd(offset_fwd),
    .offset_rev(offset_rev), .strobe_early(strobe_early),
    .strobe_late(strobe_late), .seek_start(seek_start),
    .seek_end(seek_end), .diag_mode(diag_mode));
  ddcw_ctrl_model m (.clk(clk), .attn_pin(attn_pin), .dir_pin(dir_pin),
    .word_index_bit0(word_index_bit0), .word_index_bit1(word_index_bit1),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
    .cycle_ack_line(cycle_ack_line));
  // Count seek pulses, one cycle wide
  always @(posedge clk) if (seek_start === 1'b1) n_seek++;
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Transfer, then judge ack and masked status
  task automatic go(input logic d, input logic [1:0] i, input logic [7:0] v,
                    input logic acc, input logic [7:0] mk, input logic [7:0] e);
    logic ok;
    logic [7:0] rd;
    m.xfer(d, i, v, ok, rd);
    chk("ack", {9'h0, acc}, {9'h0, ok});
    if (!d && acc) chk("status", {2'h0, e}, {2'h0, rd & mk});
  endtask
  // Write gate pulse, then fault settles
  task automatic wr;
    write_enable <= 1'b1;
    repeat (3) @(posedge clk);
    write_enable <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_select;
    chk("seek_end", 10'h1, {9'h0, seek_end});
    go(1'b1, 2'h0, 8'h92, 1'b1, 8'h00, 8'h00);
    chk("sel", 10'h1, {9'h0, drive_selected});
    chk("cyl_hi", 10'h200, cylinder_target_reg & 10'h300);
    chk("no_seek", 10'h0, 10'(n_seek));
    go(1'b1, 2'h1, 8'h5A, 1'b1, 8'h00, 8'h00);
    chk("cyl", 10'h25A, cylinder_target_reg);
    chk("seek", 10'h1, 10'(n_seek));
  endtask
  task automatic t_offset;
    go(1'b1, 2'h2, 8'h42, 1'b1, 8'h00, 8'h00);
    chk("head", 10'h2, {7'h0, head_select_field});
    chk("ofs_fwd", 10'h1, {9'h0, offset_fwd});
    wr();
    chk("ofs_fault", 10'h1, {9'h0, fault});
    go(1'b1, 2'h3, 8'h10, 1'b1, 8'h00, 8'h00);
    chk("clear", 10'h0, {9'h0, fault});
    // Strobes alone, no offset, must still fault a write
    go(1'b1, 2'h2, 8'h31, 1'b1, 8'h00, 8'h00);
    chk("stb", 10'h3, {8'h0, strobe_late, strobe_early});
    wr();
    chk("stb_fault", 10'h1, {9'h0, fault});
    go(1'b1, 2'h2, 8'h80, 1'b1, 8'h00, 8'h00);
    chk("ofs_rev", 10'h1, {9'h0, offset_rev});
    go(1'b1, 2'h3, 8'h10, 1'b1, 8'h00, 8'h00);
  endtask
  task automatic t_servo;
    go(1'b1, 2'h2, 8'h03, 1'b1, 8'h00, 8'h00);
    chk("servo", 10'h1, {9'h0, fault});
    go(1'b0, 2'h0, 8'h00, 1'b1, 8'h04, 8'h04);
    go(1'b0, 2'h1, 8'h00, 1'b1, 8'h12, 8'h12);
    go(1'b1, 2'h2, 8'h00, 1'b1, 8'h00, 8'h00);
    go(1'b1, 2'h3, 8'h10, 1'b1, 8'h00, 8'h00);
    chk("clr", 10'h0, {9'h0, fault});
    go(1'b0, 2'h1, 8'h00, 1'b1, 8'h1B, 8'h00);
  endtask
  task automatic t_wprot;
    go(1'b1, 2'h3, 8'h01, 1'b1, 8'h00, 8'h00);
    wr();
    chk("wp", 10'h1, {9'h0, fault});
    go(1'b0, 2'h0, 8'h00, 1'b1, 8'h24, 8'h24);
    go(1'b1, 2'h3, 8'h10, 1'b1, 8'h00, 8'h00);
    // Command cannot lift a strapped head
    jumper_wprot <= 3'h2;
    go(1'b1, 2'h2, 8'h01, 1'b1, 8'h00, 8'h00);
    go(1'b1, 2'h3, 8'h00, 1'b1, 8'h00, 8'h00);
    wr();
    chk("jmp", 10'h1, {9'h0, fault});
    jumper_wprot <= 3'h0;
    go(1'b1, 2'h3, 8'h10, 1'b1, 8'h00, 8'h00);
  endtask
  task automatic t_rezero;
    int n;
    go(1'b1, 2'h3, 8'h20, 1'b1, 8'h00, 8'h00);
    chk("se_lo", 10'h0, {9'h0, seek_end});
    go(1'b0, 2'h0, 8'h00, 1'b1, 8'h43, 8'h03);
    for (n = 0; n < 210 && seek_end !== 1'b1; n++) @(posedge clk);
    chk("se_hi", 10'h1, {9'h0, seek_end});
    go(1'b0, 2'h0, 8'h00, 1'b1, 8'h03, 8'h00);
  endtask
  task automatic t_diag;
    logic [7:0] w [4] = '{8'h11, 8'h04, 8'h05, 8'h3C};
    go(1'b1, 2'h3, 8'h80, 1'b1, 8'h00, 8'h00);
    chk("diag", 10'h1, {9'h0, diag_mode});
    for (int i = 0; i < 4; i++) begin
      go(1'b0, 2'(i), 8'h00, 1'b1, 8'hFF, w[i]);
    end
    go(1'b1, 2'h3, 8'h00, 1'b1, 8'h00, 8'h00);
    chk("std", 10'h0, {9'h0, diag_mode});
  endtask
  // Sensor flags and both gates at once; fault clear must drop them
  task automatic t_sense;
    speed_err_in <= 1'b1;
    power_loss_in <= 1'b1;
    read_enable <= 1'b1;
    wr();
    speed_err_in <= 1'b0;
    power_loss_in <= 1'b0;
    read_enable <= 1'b0;
    chk("sense", 10'h1, {9'h0, fault});
    go(1'b0, 2'h0, 8'h00, 1'b1, 8'h98, 8'h98);
    go(1'b0, 2'h1, 8'h00, 1'b1, 8'h10, 8'h10);
    not_ready_in <= 1'b1;
    go(1'b1, 2'h3, 8'h10, 1'b1, 8'h00, 8'h00);
    go(1'b0, 2'h0, 8'h00, 1'b1, 8'hFF, 8'h80);
    not_ready_in <= 1'b0;
    chk("sense_clr", 10'h0, {9'h0, fault});
  endtask
  task automatic t_desel;
    go(1'b1, 2'h0, 8'h12, 1'b1, 8'h00, 8'h00);
    chk("desel", 10'h0, {9'h0, drive_selected});
    go(1'b1, 2'h2, 8'h04, 1'b0, 8'h00, 8'h00);
    chk("kept", 10'h1, {7'h0, head_select_field});
    go(1'b0, 2'h0, 8'h00, 1'b0, 8'h00, 8'h00);
    chk("quiet", 10'h1, {9'h0, bus_oe_n});
    // Restrapped drive now answers to the other unit id
    straps <= 4'h1;
    go(1'b1, 2'h0, 8'h12, 1'b1, 8'h00, 8'h00);
    chk("resel", 10'h1, {9'h0, drive_selected});
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_select();
    t_offset();
    t_servo();
    t_wprot();
    t_rezero();
    t_diag();
    t_sense();
    t_desel();
    stop_test();
  end
  // Whole run needs about a thousand cycles
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
endmodule // disk_drive_control_word_decoder_test
